// *** core/wdt_presc.sv ***
// Power-of-two prescaler with a selectable tap, used for both watchdog prescalers.
// Assumes tick_i is a one-cycle enable on the same clock; sel_i picks divide by 2**sel_i.
`timescale 1ns/1ps
`default_nettype none

module wdt_presc #(
  parameter int W = 16,
  parameter int SW = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Counting
  input wire logic clr_i,
  input wire logic tick_i,
  input wire logic [SW-1:0] sel_i,
  output logic hit_o
);

  logic [W-1:0] cnt_r;
  wire [W-1:0] mask_w;

  // A tap at sel_i fires when the low sel_i bits are all ones; sel_i of 0 passes every tick
  assign mask_w = ~({W{1'b1}} << sel_i);
  assign hit_o = tick_i & ~clr_i & ((cnt_r & mask_w) == mask_w);

  always_ff @(posedge clk_i) begin
    if (srst_i || clr_i) begin
      cnt_r <= '0;
    end else if (tick_i) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule : wdt_presc

`default_nettype wire

// *** core/wdt_top.sv ***
// Watchdog timer with a dedicated 16-bit prescaler and an 8-bit prescaler shared with the
// first general timer, registers over APB.
// Assumes sleep, wake, start-up timer and fail inputs come from core logic on core_clk_i;
// the fuse enable and oscillator ready level come from outside and are synchronised.
`timescale 1ns/1ps
`default_nettype none

`include "wdt_regs.svh"

module wdt_top
  import wdt_pkg::*;
#(
  parameter int LF_DIV = `WDT_LF_DIV
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Pins from outside the clock domain
  input wire logic fuse_watchdog_enable_i,
  input wire logic low_freq_osc_ready_i,
  // Core and oscillator events
  input wire logic clear_watchdog_instr_i,
  input wire logic osc_fail_i,
  input wire logic osc_startup_timer_i,
  input wire logic sleep_i,
  input wire logic wake_i,
  input wire logic [2:0] sys_clk_mode_i,
  input wire logic sys_clk_is_lf_i,
  // Shared prescaler when assigned to the first timer
  input wire logic first_timer_tick_i,
  output logic first_timer_presc_tick_o,
  // Watchdog results
  output logic wdt_reset_o,
  output logic wdt_wake_o,
  output logic lowfreq_stable_flag_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Registers and state
  wdt_ctrl_t ctrl_r;
  wdt_opt_t opt_r;
  logic [1:0] istat_r;
  logic [1:0] imask_r;
  wdt_state_t state_r;
  wdt_state_t state_nxt;
  logic ost_seen_r;
  logic [11:0] lf_cnt_r;
  logic fuse_meta_r;
  logic fuse_sync_r;
  logic lfrdy_meta_r;
  logic lfrdy_sync_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic wdt_reset_r;
  logic wdt_wake_r;
  logic ft_tick_r;
  logic lts_r;

  // ---------------------------------------------------------------
  // APB decode
  wire acc_w;
  wire first_w;
  wire done_w;
  wire wr_w;
  wire hit_ctrl_w;
  wire hit_opt_w;
  wire hit_istat_w;
  wire hit_imask_w;
  wire hit_stat_w;
  wire mapped_w;
  wire [31:0] rdata_w;
  wire [31:0] stat_w;

  assign acc_w = psel_i & penable_i;
  // One wait state: answer prepared in the first access cycle, write lands when pready is seen
  assign first_w = acc_w & ~pready_r;
  assign done_w = acc_w & pready_r;
  assign wr_w = done_w & pwrite_i;
  assign hit_ctrl_w = (paddr_i == `WDT_OFF_CTRL);
  assign hit_opt_w = (paddr_i == `WDT_OFF_OPT);
  assign hit_istat_w = (paddr_i == `WDT_OFF_ISTAT);
  assign hit_imask_w = (paddr_i == `WDT_OFF_IMASK);
  assign hit_stat_w = (paddr_i == `WDT_OFF_STAT);
  assign mapped_w = hit_ctrl_w | hit_opt_w | hit_istat_w | hit_imask_w | hit_stat_w;

  assign stat_w = {27'h0, lts_r, state_r, fuse_sync_r, (state_r == WDT_ST_RUN)};
  assign rdata_w = hit_ctrl_w ? {27'h0, ctrl_r} :
                   hit_opt_w ? {28'h0, opt_r} :
                   hit_istat_w ? {30'h0, istat_r} :
                   hit_imask_w ? {30'h0, imask_r} :
                   hit_stat_w ? stat_w : 32'h0;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= first_w;
      pslverr_r <= first_w & ~mapped_w;
      if (first_w) begin
        prdata_r <= pwrite_i ? 32'h0 : rdata_w;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control and option registers
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctrl_r <= `WDT_CTRL_RST;
      opt_r <= `WDT_OPT_RST;
    end else begin
      if (wr_w && hit_ctrl_w) begin
        ctrl_r <= pwdata_i[`WDT_CTRL_RATE_MSB:`WDT_CTRL_EN_BIT];
      end
      if (wr_w && hit_opt_w) begin
        opt_r <= pwdata_i[`WDT_OPT_PSA_BIT:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Synchronisers for levels that come from pins
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      fuse_meta_r <= 1'b0;
      fuse_sync_r <= 1'b0;
      lfrdy_meta_r <= 1'b0;
      lfrdy_sync_r <= 1'b0;
    end else begin
      fuse_meta_r <= fuse_watchdog_enable_i;
      fuse_sync_r <= fuse_meta_r;
      lfrdy_meta_r <= low_freq_osc_ready_i;
      lfrdy_sync_r <= lfrdy_meta_r;
    end
  end

  // Stable flag follows the system's own use of the oscillator, never the watchdog's
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      lts_r <= 1'b0;
    end else begin
      lts_r <= lfrdy_sync_r & sys_clk_is_lf_i;
    end
  end

  // ---------------------------------------------------------------
  // Low-frequency time base, kept free-running so clears never skew its phase
  wire lf_tick_w;

  assign lf_tick_w = (lf_cnt_r == 12'(LF_DIV - 1));

  always_ff @(posedge core_clk_i) begin
    if (srst_i || lf_tick_w) begin
      lf_cnt_r <= 12'h000;
    end else begin
      lf_cnt_r <= lf_cnt_r + 12'h001;
    end
  end

  // ---------------------------------------------------------------
  // Enable, wake and clear conditions
  wire en_w;
  wire crystal_w;
  wire wake_quick_w;
  wire wake_xtal_w;
  wire clear_w;
  wire count_tick_w;

  assign en_w = fuse_sync_r | ctrl_r.soft_watchdog_enable;
  assign crystal_w = (sys_clk_mode_i == WDT_CLK_LP) ||
                     (sys_clk_mode_i == WDT_CLK_XT) ||
                     (sys_clk_mode_i == WDT_CLK_HS);
  assign wake_quick_w = wake_i & ~crystal_w;
  assign wake_xtal_w = wake_i & crystal_w;

  // Any of these empties the dedicated prescaler, and the shared one only while it is assigned to the watchdog
  assign clear_w = ~en_w |
                   clear_watchdog_instr_i |
                   osc_fail_i |
                   osc_startup_timer_i |
                   wake_quick_w |
                   wake_xtal_w |
                   (state_r != WDT_ST_RUN);

  assign count_tick_w = lf_tick_w & ~clear_w;

  // ---------------------------------------------------------------
  // Run state: HOLD waits for the start-up timer to begin and then end
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      WDT_ST_OFF: begin
        if (wake_xtal_w) begin
          state_nxt = WDT_ST_HOLD;
        end else if (en_w && !osc_startup_timer_i) begin
          state_nxt = WDT_ST_RUN;
        end
      end
      WDT_ST_RUN: begin
        if (wake_xtal_w || osc_startup_timer_i) begin
          state_nxt = WDT_ST_HOLD;
        end else if (!en_w) begin
          state_nxt = WDT_ST_OFF;
        end
      end
      WDT_ST_HOLD: begin
        // Resume only once the start-up count has run and expired
        if ((ost_seen_r || osc_startup_timer_i) && !osc_startup_timer_i) begin
          state_nxt = en_w ? WDT_ST_RUN : WDT_ST_OFF;
        end
      end
      default: begin
        state_nxt = WDT_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_r <= WDT_ST_OFF;
      ost_seen_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ost_seen_r <= (state_nxt == WDT_ST_HOLD) & (ost_seen_r | osc_startup_timer_i);
    end
  end

  // ---------------------------------------------------------------
  // Dedicated 16-bit prescaler; codes above the top one saturate at 2**16
  wire [4:0] main_sel_w;
  wire main_hit_w;

  assign main_sel_w = (ctrl_r.rate > `WDT_RATE_MAX) ? `WDT_RATE_TOP_SEL :
                      (5'(ctrl_r.rate) + `WDT_RATE_BASE);

  wdt_presc #(
    .W(16),
    .SW(5)
  ) u_main_presc (
    .clk_i(core_clk_i),
    .srst_i(srst_i),
    .clr_i(clear_w),
    .tick_i(count_tick_w),
    .sel_i(main_sel_w),
    .hit_o(main_hit_w)
  );

  // ---------------------------------------------------------------
  // Shared 8-bit prescaler: watchdog divides 1:2**n, the first timer 1:2**(n+1)
  wire psa_w;
  wire [3:0] sh_sel_w;
  wire sh_tick_w;
  wire sh_clr_w;
  wire sh_hit_w;
  wire timeout_w;

  assign psa_w = opt_r.prescaler_assign_bit;
  assign sh_sel_w = psa_w ? {1'b0, opt_r.prescale_rate_field} :
                    ({1'b0, opt_r.prescale_rate_field} + 4'h1);
  // Only one owner feeds it, so the other cannot disturb its count
  assign sh_tick_w = psa_w ? main_hit_w : first_timer_tick_i;
  assign sh_clr_w = psa_w & clear_w;

  wdt_presc #(
    .W(8),
    .SW(4)
  ) u_shared_presc (
    .clk_i(core_clk_i),
    .srst_i(srst_i),
    .clr_i(sh_clr_w),
    .tick_i(sh_tick_w),
    .sel_i(sh_sel_w),
    .hit_o(sh_hit_w)
  );

  assign timeout_w = psa_w ? sh_hit_w : main_hit_w;

  // ---------------------------------------------------------------
  // Time-out results and first-timer tick
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wdt_reset_r <= 1'b0;
      wdt_wake_r <= 1'b0;
      ft_tick_r <= 1'b0;
    end else begin
      wdt_reset_r <= timeout_w & ~sleep_i;
      wdt_wake_r <= timeout_w & sleep_i;
      ft_tick_r <= ~psa_w & sh_hit_w;
    end
  end

  // ---------------------------------------------------------------
  // Sticky interrupt status, write one to clear; a new event beats the clear
  wire [1:0] ev_w;
  wire [1:0] iclr_w;

  assign ev_w = {osc_fail_i, timeout_w};
  assign iclr_w = (wr_w && hit_istat_w) ? pwdata_i[1:0] : 2'h0;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      istat_r <= `WDT_IRQ_RST;
      imask_r <= `WDT_IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      istat_r <= (istat_r & ~iclr_w) | ev_w;
      if (wr_w && hit_imask_w) begin
        imask_r <= pwdata_i[1:0];
      end
      irq_r <= |(istat_r & imask_r);
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign first_timer_presc_tick_o = ft_tick_r;
  assign wdt_reset_o = wdt_reset_r;
  assign wdt_wake_o = wdt_wake_r;
  assign lowfreq_stable_flag_o = lts_r;
  assign irq_o = irq_r;

endmodule : wdt_top

`default_nettype wire

// *** pkg/wdt_pkg.sv ***
// Types shared by the watchdog block: control fields, clock modes and FSM states.
// Assumes nothing of its surroundings.
package wdt_pkg;

  typedef struct packed {
    logic [3:0] rate;
    logic soft_watchdog_enable;
  } wdt_ctrl_t;

  typedef struct packed {
    logic prescaler_assign_bit;
    logic [2:0] prescale_rate_field;
  } wdt_opt_t;

  typedef enum logic [2:0] {
    WDT_CLK_LP = 3'h0,
    WDT_CLK_XT = 3'h1,
    WDT_CLK_HS = 3'h2,
    WDT_CLK_EXTERNAL_RC_CLOCK = 3'h3,
    WDT_CLK_INTERNAL_OSC_CLOCK = 3'h4,
    WDT_CLK_EXTERNAL_CLOCK_INPUT = 3'h5,
    WDT_CLK_SECOSC = 3'h6
  } wdt_clk_mode_t;

  typedef enum logic [1:0] {
    WDT_ST_OFF = 2'b00,
    WDT_ST_RUN = 2'b01,
    WDT_ST_HOLD = 2'b10
  } wdt_state_t;

endpackage : wdt_pkg

// *** pkg/wdt_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the watchdog block.
// Assumes a 100 MHz core clock and APB byte addresses in the low eight address bits.
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// Register byte offsets
`define WDT_OFF_CTRL 8'h00
`define WDT_OFF_OPT 8'h04
`define WDT_OFF_ISTAT 8'h08
`define WDT_OFF_IMASK 8'h0C
`define WDT_OFF_STAT 8'h10

// Control register fields
`define WDT_CTRL_EN_BIT 0
`define WDT_CTRL_RATE_LSB 1
`define WDT_CTRL_RATE_MSB 4
`define WDT_CTRL_RST 5'h08

// Option register fields: assign bit and shared rate
`define WDT_OPT_PSA_BIT 3
`define WDT_OPT_RST 4'hF

// Interrupt bits
`define WDT_IRQ_TIMEOUT 0
`define WDT_IRQ_OSCFAIL 1
`define WDT_IRQ_RST 2'h0

// Rate code range of the dedicated prescaler; code 0 divides by 2**5
`define WDT_RATE_BASE 5'h05
`define WDT_RATE_MAX 4'hB
`define WDT_RATE_TOP_SEL 5'h10

// Timing: low-frequency oscillator emulated from the core clock
`define WDT_CORE_CLK_HZ 100000000
`define WDT_LF_OSC_HZ 31000
`define WDT_LF_DIV ((`WDT_CORE_CLK_HZ + `WDT_LF_OSC_HZ - 1) / `WDT_LF_OSC_HZ)

`endif

// *** sim/wdt_props.sv ***
// Port-level assertions of the watchdog block.
// Assumes it is bound into wdt_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module wdt_props
  import wdt_pkg::*;
#(
  parameter int LF_DIV = 4
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Inputs watched
  input wire logic clear_watchdog_instr_i,
  input wire logic osc_fail_i,
  input wire logic osc_startup_timer_i,
  input wire logic sleep_i,
  input wire logic wake_i,
  input wire logic [2:0] sys_clk_mode_i,
  input wire logic sys_clk_is_lf_i,
  input wire logic first_timer_tick_i,
  // Outputs watched
  input wire logic pready_o,
  input wire logic first_timer_presc_tick_o,
  input wire logic wdt_reset_o,
  input wire logic wdt_wake_o,
  input wire logic lowfreq_stable_flag_o,
  input wire logic irq_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  // Legal time-outs are 32 ticks apart at least, so eight quiet cycles never hide one
  sequence quiet8;
    (!wdt_reset_o && !wdt_wake_o) [*8];
  endsequence
  sequence crystal_wake;
    wake_i && (sys_clk_mode_i inside {WDT_CLK_LP, WDT_CLK_XT, WDT_CLK_HS});
  endsequence

  reset_quiet_a: assert property (disable iff (1'b0) srst_i |=>
    !wdt_reset_o && !wdt_wake_o && !irq_o && !pready_o) else $error("output active after reset");
  clear_quiet_a: assert property (clear_watchdog_instr_i |=> quiet8)
    else $error("time-out right after clear");
  fail_quiet_a: assert property (osc_fail_i |=> quiet8)
    else $error("time-out right after oscillator failure");
  startup_hold_a: assert property (osc_startup_timer_i |=> quiet8)
    else $error("time-out while start-up timer runs");
  crystal_hold_a: assert property (crystal_wake |=> quiet8)
    else $error("time-out right after crystal wake");
  reset_pulse_a: assert property (wdt_reset_o |=> quiet8)
    else $error("time-out pulse too long");
  awake_reset_a: assert property (wdt_reset_o && $stable(sleep_i) |-> !sleep_i)
    else $error("reset pulse while asleep");
  asleep_wake_a: assert property (wdt_wake_o && $stable(sleep_i) |-> sleep_i)
    else $error("wake pulse while awake");
  stable_flag_a: assert property (lowfreq_stable_flag_o |-> $past(sys_clk_is_lf_i))
    else $error("stable flag without low-frequency system clock");
  shared_tick_a: assert property (first_timer_presc_tick_o |-> $past(first_timer_tick_i))
    else $error("shared prescaler output without timer tick");
endmodule : wdt_props

bind wdt_top wdt_props #(.LF_DIV(LF_DIV)) u_props (.core_clk_i, .srst_i,
  .clear_watchdog_instr_i, .osc_fail_i, .osc_startup_timer_i, .sleep_i, .wake_i,
  .sys_clk_mode_i, .sys_clk_is_lf_i, .first_timer_tick_i, .pready_o,
  .first_timer_presc_tick_o, .wdt_reset_o, .wdt_wake_o, .lowfreq_stable_flag_o, .irq_o);

`default_nettype wire

// *** sim/wdt_top_bench.sv ***
// Self-checking bench of the watchdog block, registers over APB, events on pins.
// Assumes a shortened low-frequency divider; time-outs are judged with a phase tolerance.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: %h, expected %h", $time, (a), (e)); end end

module wdt_top_bench import wdt_pkg::*; ();
  localparam int LF = 4;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h00000000;
  logic fuse_watchdog_enable_i = 1'b0, low_freq_osc_ready_i = 1'b0, osc_fail_i = 1'b0;
  logic clear_watchdog_instr_i = 1'b0, osc_startup_timer_i = 1'b0, sleep_i = 1'b0;
  logic wake_i = 1'b0, sys_clk_is_lf_i = 1'b0, first_timer_tick_i = 1'b0;
  logic [2:0] sys_clk_mode_i = WDT_CLK_INTERNAL_OSC_CLOCK;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, first_timer_presc_tick_o, wdt_reset_o, wdt_wake_o;
  logic lowfreq_stable_flag_o, irq_o, er;
  int n_errors = 0, checked = 0, nres = 0, n, k;

  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    if (wdt_reset_o === 1'b1) nres <= nres + 1;
  end

  wdt_top #(.LF_DIV(LF)) DUT (.core_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .fuse_watchdog_enable_i,
    .low_freq_osc_ready_i, .clear_watchdog_instr_i, .osc_fail_i, .osc_startup_timer_i,
    .sleep_i, .wake_i, .sys_clk_mode_i, .sys_clk_is_lf_i, .first_timer_tick_i,
    .first_timer_presc_tick_o, .wdt_reset_o, .wdt_wake_o, .lowfreq_stable_flag_o, .irq_o);

  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk_i);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  // Counts cycles until either time-out pulse shows; one edge always passes first, so a
  // pulse still standing from the previous wait is not taken again
  task automatic wp(input int lim);
    n = 1;
    @(posedge core_clk_i);
    while (n < lim && wdt_reset_o !== 1'b1 && wdt_wake_o !== 1'b1) begin
      @(posedge core_clk_i);
      n++;
    end
  endtask : wp

  // Tick phase is free-running, so a time-out may land a few ticks either way
  function automatic logic near(input int v, input int e);
    return (v >= e - 2 * LF - 2) && (v <= e + 2 * LF + 2);
  endfunction : near

  task automatic tk();
    n = 0;
    for (int i = 0; i < 24; i++) begin
      first_timer_tick_i <= (i % 3 == 0);
      @(posedge core_clk_i);
      n += (first_timer_presc_tick_o === 1'b1);
    end
  endtask : tk

  task automatic wake_up(input logic [2:0] m);
    sys_clk_mode_i <= m;
    @(posedge core_clk_i);
    wake_i <= 1'b1;
    sleep_i <= 1'b0;
    @(posedge core_clk_i);
    wake_i <= 1'b0;
  endtask : wake_up

  task automatic t_regs();
    apb(1'b0, `WDT_OFF_CTRL, 32'h00000000);
    `CHK(rd, 32'h00000008)
    apb(1'b0, `WDT_OFF_OPT, 32'h00000000);
    `CHK(rd, 32'h0000000F)
    apb(1'b0, 8'h14, 32'h00000000);
    `CHK({er, rd}, 33'h100000000)
    apb(1'b1, `WDT_OFF_CTRL, 32'hFFFFFFFE);
    apb(1'b0, `WDT_OFF_CTRL, 32'h00000000);
    `CHK(rd, 32'h0000001E)
    $display("test regs done");
  endtask : t_regs

  task automatic t_rates();
    apb(1'b1, `WDT_OFF_OPT, 32'h00000000);
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, `WDT_OFF_CTRL, 32'h00000000);
      apb(1'b1, `WDT_OFF_CTRL, 32'((r << 1) | 1));
      wp(2000);
      `CHK(near(n, (32 << r) * LF), 1'b1)
      `CHK({wdt_reset_o, wdt_wake_o}, 2'b10)
    end
    apb(1'b1, `WDT_OFF_CTRL, 32'h00000000);
    apb(1'b0, `WDT_OFF_ISTAT, 32'h00000000);
    `CHK({rd[1:0], irq_o}, 3'b010)
    apb(1'b1, `WDT_OFF_IMASK, 32'h00000001);
    cyc(2);
    `CHK(irq_o, 1'b1)
    apb(1'b1, `WDT_OFF_ISTAT, 32'h00000001);
    cyc(2);
    `CHK(irq_o, 1'b0)
    $display("test rates done");
  endtask : t_rates

  task automatic t_shared();
    apb(1'b1, `WDT_OFF_OPT, 32'h00000009);
    apb(1'b1, `WDT_OFF_CTRL, 32'h00000001);
    wp(2000);
    `CHK(near(n, 64 * LF), 1'b1)
    apb(1'b1, `WDT_OFF_CTRL, 32'h00000000);
    tk();
    `CHK(n, 0)
    apb(1'b1, `WDT_OFF_OPT, 32'h00000000);
    tk();
    `CHK(n, 4)
    $display("test shared done");
  endtask : t_shared

  task automatic t_clear();
    apb(1'b1, `WDT_OFF_CTRL, 32'h00000001);
    k = nres;
    for (int i = 0; i < 8; i++) begin
      cyc(90);
      if (i % 2) osc_fail_i <= 1'b1;
      else clear_watchdog_instr_i <= 1'b1;
      @(posedge core_clk_i);
      osc_fail_i <= 1'b0;
      clear_watchdog_instr_i <= 1'b0;
    end
    `CHK(nres, k)
    apb(1'b1, `WDT_OFF_CTRL, 32'h00000000);
    apb(1'b0, `WDT_OFF_ISTAT, 32'h00000000);
    `CHK(rd[1], 1'b1)
    apb(1'b1, `WDT_OFF_ISTAT, 32'h00000003);
    $display("test clear done");
  endtask : t_clear

  task automatic t_enable();
    k = nres;
    cyc(400);
    `CHK(nres, k)
    fuse_watchdog_enable_i <= 1'b1;
    wp(400);
    `CHK(wdt_reset_o, 1'b1)
    fuse_watchdog_enable_i <= 1'b0;
    apb(1'b1, `WDT_OFF_CTRL, 32'h00000001);
    osc_startup_timer_i <= 1'b1;
    k = nres;
    cyc(400);
    `CHK(nres, k)
    osc_startup_timer_i <= 1'b0;
    wp(400);
    `CHK(near(n, 32 * LF), 1'b1)
    $display("test enable done");
  endtask : t_enable

  task automatic t_sleep();
    // Crystal modes LP, XT and HS: held cleared until the start-up timer has run
    for (int m = 0; m < 3; m++) begin
      sleep_i <= 1'b1;
      wp(400);
      `CHK({wdt_reset_o, wdt_wake_o}, 2'b01)
      wake_up(3'(m));
      k = nres;
      cyc(200);
      `CHK(nres, k)
      osc_startup_timer_i <= 1'b1;
      cyc(20);
      osc_startup_timer_i <= 1'b0;
      wp(400);
      `CHK(near(n, 32 * LF), 1'b1)
    end
    // Other clock modes: one clear at wake, counting goes on at once
    for (int m = 3; m < 7; m++) begin
      sleep_i <= 1'b1;
      cyc(60);
      wake_up(3'(m));
      wp(400);
      `CHK(near(n, 32 * LF), 1'b1)
    end
    low_freq_osc_ready_i <= 1'b1;
    cyc(6);
    `CHK(lowfreq_stable_flag_o, 1'b0)
    sys_clk_is_lf_i <= 1'b1;
    cyc(6);
    `CHK(lowfreq_stable_flag_o, 1'b1)
    apb(1'b1, `WDT_OFF_CTRL, 32'h00000000);
    $display("test sleep done");
  endtask : t_sleep

  task automatic report_and_stop();
    $display("mismatches %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial begin
    cyc(3);
    srst_i <= 1'b0;
    t_regs();
    t_rates();
    t_shared();
    t_clear();
    t_enable();
    t_sleep();
    report_and_stop();
  end

  // The whole run takes well under 10000 cycles
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
endmodule : wdt_top_bench

`default_nettype wire
